/* verilog/safe_stop_defs.svh */
// constants of the safe stop monitor: timing, register map, field positions
// assumes a 40 MHz core clock
`ifndef SAFE_STOP_DEFS_SVH
`define SAFE_STOP_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS     25
`define NS_PER_MS         1000000
`define MS_TICK_CYCLES    (`NS_PER_MS / `CLK_PERIOD_NS)
`define DISCREPANCY_MS    16'h0064

// ----------------------------------------
// register map
// ----------------------------------------
`define REG_CTRL          8'h00
`define REG_PARAM_BASE    8'h04
`define REG_MAP           8'h2C
`define REG_STATUS        8'h30
`define NUM_PARAMS        10
`define PARAM_NONE        4'hF

// parameter slots, byte address = base + 4 * slot
`define P_STOP_DEADLINE   0
`define P_STOP_DWELL      1
`define P_STOP_DELAY      2
`define P_STOP_WINDOW     3
`define P_STOP_DECEL      4
`define P_SS_DEADLINE     5
`define P_SS_DWELL        6
`define P_SS_DELAY        7
`define P_SS_WINDOW       8
`define P_SS_DECEL        9

// parameter reset values
`define RST_STOP_DEADLINE 16'h0002
`define RST_STOP_DWELL    16'h0001
`define RST_STOP_DELAY    16'h0001
`define RST_STOP_WINDOW   16'h0001
`define RST_STOP_DECEL    16'h0000
`define RST_SS_DEADLINE   16'h0002
`define RST_SS_DWELL      16'h0001
`define RST_SS_DELAY      16'h0001
`define RST_SS_WINDOW     16'h0000
`define RST_SS_DECEL      16'h0000

// control register fields
`define CTRL_DUAL         0
`define CTRL_FB_EN        1
`define CTRL_STOP_USED    2
`define CTRL_RAMP_EN      5
`define CTRL_STOP_DEC_EN  6
`define CTRL_SS_DEC_EN    7
`define CTRL_SS_TO_STOP   8
`define CTRL_SS_USED      9
`define RST_CTRL          16'h0004

// map register fields
`define MAP_STOP          0
`define MAP_SS            3
`define MAP_SEL0          8
`define MAP_SEL1          12
`define RST_MAP           16'h7700

// standstill internal state codes
`define SS_CODE_IDLE      3'h0
`define SS_CODE_RUN       3'h1
`define SS_CODE_HOLD      3'h2
`define SS_CODE_FAIL      3'h5

`endif

/* verilog/safe_stop_pkg.sv */
// types of the safe stop monitor
// assumes safe_stop_defs.svh for all numeric constants
package safe_stop_pkg;

  typedef enum logic [1:0] {STOP_IDLE, STOP_RUN, STOP_OFF} stop_state_t;
  typedef enum logic [1:0] {SS_IDLE, SS_RUN, SS_HOLD, SS_FAIL} ss_state_t;

  typedef struct packed {
    logic [2:0] fieldbus_stop;
    logic [1:0] fieldbus_standstill;
    logic       fault_to_stop;
    logic       fault_to_standstill;
  } stop_request_t;

  typedef struct packed {
    logic signed [15:0] velocity;
    logic        [15:0] decel;
  } motion_t;

  typedef struct packed {
    logic [2:0] stop_active;
    logic       torque_off;
    logic [1:0] standstill_active;
    logic [1:0] hold_request;
    logic       standstill_fault;
    logic       input_failure;
    logic [1:0] test_pulsed_output;
  } stop_status_t;

endpackage

/* verilog/safe_stop_monitor.sv */
// per-axis safe stop supervision: three controlled stops, two stops to standstill
// assumes requests and motion come from core_clk logic; the safe input pair is asynchronous
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "safe_stop_defs.svh"

module safe_stop_monitor #(
  parameter int TICK_CYCLES = `MS_TICK_CYCLES
) (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  // register port
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [15:0]                  reg_wdata,
  input  wire logic                         reg_write,
  input  wire logic                         reg_read,
  output      logic [15:0]                  reg_rdata,
  // safe input pair, asynchronous
  input  wire logic [1:0]                   dual_safe_input_pair,
  // activation requests and motion feedback
  input  wire safe_stop_pkg::stop_request_t request_in,
  input  wire safe_stop_pkg::motion_t       motion_in,
  // status
  output      safe_stop_pkg::stop_status_t  status_out
);
  import safe_stop_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] param_index(input logic [7:0] addr);
    logic [3:0] idx;
    idx = `PARAM_NONE;
    for (int k = 0; k < `NUM_PARAMS; k++) begin
      if (addr == 8'(`REG_PARAM_BASE + 4 * k)) begin
        idx = 4'(k);
      end
    end
    return idx;
  endfunction

  function automatic logic [15:0] param_reset(input int k);
    case (k)
      `P_STOP_DEADLINE: return `RST_STOP_DEADLINE;
      `P_STOP_DWELL:    return `RST_STOP_DWELL;
      `P_STOP_DELAY:    return `RST_STOP_DELAY;
      `P_STOP_WINDOW:   return `RST_STOP_WINDOW;
      `P_STOP_DECEL:    return `RST_STOP_DECEL;
      `P_SS_DEADLINE:   return `RST_SS_DEADLINE;
      `P_SS_DWELL:      return `RST_SS_DWELL;
      `P_SS_DELAY:      return `RST_SS_DELAY;
      `P_SS_WINDOW:     return `RST_SS_WINDOW;
      default:          return `RST_SS_DECEL;
    endcase
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic en);
    return (en && v != 16'hFFFF) ? 16'(v + 16'h0001) : v;
  endfunction

  function automatic logic [15:0] speed_mag(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic [2:0] ss_code(input ss_state_t s);
    case (s)
      SS_RUN:  return `SS_CODE_RUN;
      SS_HOLD: return `SS_CODE_HOLD;
      SS_FAIL: return `SS_CODE_FAIL;
      default: return `SS_CODE_IDLE;
    endcase
  endfunction

  function automatic logic pick(input logic [5:0] sv, input logic [2:0] sel);
    return (sel < 3'h6) ? sv[sel] : 1'b0;
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0]  ctrl_q, ctrl_d;
  logic [15:0]  map_q, map_d;
  logic [15:0]  param_q [`NUM_PARAMS];
  logic [15:0]  param_d [`NUM_PARAMS];
  logic [15:0]  rdata_d;
  logic [3:0]   wr_idx, rd_idx;
  stop_status_t status_d;
  logic [2:0]   ss0_code, ss1_code;

  always_comb begin
    ctrl_d  = ctrl_q;
    map_d   = map_q;
    param_d = param_q;
    rdata_d = 16'h0000;
    wr_idx  = param_index(reg_addr);
    rd_idx  = wr_idx;
    if (reg_write) begin
      if (reg_addr == `REG_CTRL) begin
        ctrl_d = reg_wdata;
      end else if (reg_addr == `REG_MAP) begin
        map_d = reg_wdata;
      end else if (wr_idx != `PARAM_NONE) begin
        param_d[wr_idx] = reg_wdata;
      end
    end
    if (reg_read) begin
      if (reg_addr == `REG_CTRL) begin
        rdata_d = ctrl_q;
      end else if (reg_addr == `REG_MAP) begin
        rdata_d = map_q;
      end else if (reg_addr == `REG_STATUS) begin
        rdata_d = {status_out.standstill_fault, ss1_code, ss0_code, status_out.input_failure,
                   status_out.hold_request, status_out.standstill_active, status_out.torque_off,
                   status_out.stop_active};
      end else if (rd_idx != `PARAM_NONE) begin
        rdata_d = param_q[rd_idx];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q    <= `RST_CTRL;
      map_q     <= `RST_MAP;
      reg_rdata <= 16'h0000;
      for (int k = 0; k < `NUM_PARAMS; k++) begin
        param_q[k] <= param_reset(k);
      end
    end else begin
      ctrl_q    <= ctrl_d;
      map_q     <= map_d;
      param_q   <= param_d;
      reg_rdata <= rdata_d;
    end
  end

  wire       dual_mode = ctrl_q[`CTRL_DUAL];
  wire       fb_en     = ctrl_q[`CTRL_FB_EN];
  wire [2:0] stop_used = ctrl_q[`CTRL_STOP_USED +: 3];
  wire [1:0] ss_used   = ctrl_q[`CTRL_SS_USED +: 2];
  wire       ramp_en   = ctrl_q[`CTRL_RAMP_EN];
  wire       ss_react  = ctrl_q[`CTRL_SS_TO_STOP];
  wire [15:0] speed    = speed_mag(motion_in.velocity);

  // ----------------------------------------
  // millisecond tick and safe inputs
  // ----------------------------------------
  logic [15:0] div_q, div_d, disc_q, disc_d;
  logic        tick_q, tick_d, fail_q, fail_d, sreq_q, sreq_d;
  logic [1:0]  sin1_q, sin2_q;
  logic        mismatch;

  always_comb begin
    tick_d   = (div_q == 16'(TICK_CYCLES - 1));
    div_d    = tick_d ? 16'h0000 : 16'(div_q + 16'h0001);
    mismatch = dual_mode & (sin2_q[0] ^ sin2_q[1]);
    disc_d   = mismatch ? sat_inc(disc_q, tick_q) : 16'h0000;
    fail_d   = mismatch & (fail_q | (disc_q > `DISCREPANCY_MS));
    sreq_d   = ~sin2_q[0] | (dual_mode & ~sin2_q[1]);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
      disc_q <= 16'h0000;
      fail_q <= 1'b0;
      sreq_q <= 1'b0;
      sin1_q <= 2'h3;
      sin2_q <= 2'h3;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
      disc_q <= disc_d;
      fail_q <= fail_d;
      sreq_q <= sreq_d;
      sin1_q <= dual_safe_input_pair;
      sin2_q <= sin1_q;
    end
  end

  // ----------------------------------------
  // controlled stop instances
  // ----------------------------------------
  logic [2:0] stop_act, stop_off;
  logic [1:0] ss_act, ss_hold, ss_fail;
  logic       ss_to_stop;

  assign ss_to_stop = (|ss_fail) & ss_react;

  for (genvar i = 0; i < 3; i++) begin : g_stop
    stop_state_t st_q, st_d;
    logic [15:0] el_q, el_d, dw_q, dw_d;
    logic        req, in_win, dec_bad;

    always_comb begin
      st_d    = st_q;
      el_d    = el_q;
      dw_d    = dw_q;
      req     = (stop_used[i] & ((fb_en & request_in.fieldbus_stop[i]) | (map_q[`MAP_STOP + i] & sreq_q)))
              | ((i == 0) & (request_in.fault_to_stop | fail_q | ss_to_stop));
      in_win  = speed <= param_q[`P_STOP_WINDOW];
      dec_bad = ramp_en & ctrl_q[`CTRL_STOP_DEC_EN] & (el_q >= param_q[`P_STOP_DELAY])
              & (motion_in.decel > param_q[`P_STOP_DECEL]);
      case (st_q)
        STOP_IDLE: begin
          if (req) begin
            st_d = STOP_RUN;
            el_d = 16'h0000;
            dw_d = 16'h0000;
          end
        end
        STOP_RUN: begin
          el_d = sat_inc(el_q, tick_q);
          dw_d = in_win ? sat_inc(dw_q, tick_q) : 16'h0000;
          if (el_q >= param_q[`P_STOP_DEADLINE]) begin
            st_d = STOP_OFF;
          end else if (ramp_en & in_win & (dw_q >= param_q[`P_STOP_DWELL])) begin
            st_d = STOP_OFF;
          end else if (dec_bad) begin
            st_d = STOP_OFF;
          end
        end
        STOP_OFF: begin
          if (!req) begin
            st_d = STOP_IDLE;
          end
        end
        default: st_d = STOP_IDLE;
      endcase
    end

    always_ff @(posedge core_clk) begin
      if (reset) begin
        st_q <= STOP_IDLE;
        el_q <= 16'h0000;
        dw_q <= 16'h0000;
      end else begin
        st_q <= st_d;
        el_q <= el_d;
        dw_q <= dw_d;
      end
    end

    assign stop_act[i] = (st_q != STOP_IDLE);
    assign stop_off[i] = (st_q == STOP_OFF);
  end

  // ----------------------------------------
  // stop to standstill instances
  // ----------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_ss
    ss_state_t   st_q, st_d;
    logic [15:0] el_q, el_d, dw_q, dw_d;
    logic        req, in_win, dec_bad;

    always_comb begin
      st_d    = st_q;
      el_d    = el_q;
      dw_d    = dw_q;
      req     = (ss_used[i] & ((fb_en & request_in.fieldbus_standstill[i]) | (map_q[`MAP_SS + i] & sreq_q)))
              | ((i == 0) & request_in.fault_to_standstill);
      in_win  = speed <= param_q[`P_SS_WINDOW];
      dec_bad = ctrl_q[`CTRL_SS_DEC_EN] & (el_q >= param_q[`P_SS_DELAY])
              & (motion_in.decel > param_q[`P_SS_DECEL]);
      case (st_q)
        SS_IDLE: begin
          if (req) begin
            st_d = SS_RUN;
            el_d = 16'h0000;
            dw_d = 16'h0000;
          end
        end
        SS_RUN: begin
          el_d = sat_inc(el_q, tick_q);
          dw_d = in_win ? sat_inc(dw_q, tick_q) : 16'h0000;
          if (dec_bad) begin
            st_d = SS_FAIL;
          end else if (el_q >= param_q[`P_SS_DEADLINE]) begin
            st_d = SS_HOLD;
          end else if (in_win & (dw_q >= param_q[`P_SS_DWELL])) begin
            st_d = SS_HOLD;
          end
        end
        SS_HOLD, SS_FAIL: begin
          if (!req) begin
            st_d = SS_IDLE;
          end
        end
        default: st_d = SS_IDLE;
      endcase
    end

    always_ff @(posedge core_clk) begin
      if (reset) begin
        st_q <= SS_IDLE;
        el_q <= 16'h0000;
        dw_q <= 16'h0000;
      end else begin
        st_q <= st_d;
        el_q <= el_d;
        dw_q <= dw_d;
      end
    end

    assign ss_act[i]  = (st_q != SS_IDLE);
    assign ss_hold[i] = (st_q == SS_HOLD);
    assign ss_fail[i] = (st_q == SS_FAIL);
  end

  assign ss0_code = ss_code(g_ss[0].st_q);
  assign ss1_code = ss_code(g_ss[1].st_q);

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  logic [5:0] status_vec;

  always_comb begin
    status_d                    = '0;
    status_d.stop_active        = stop_act;
    status_d.torque_off         = (|stop_off) | ((|ss_fail) & ~ss_react);
    status_d.standstill_active  = ss_act;
    status_d.hold_request       = ss_hold;
    status_d.standstill_fault   = |ss_fail;
    status_d.input_failure      = fail_q;
    status_vec                  = {status_out.torque_off, status_out.standstill_active, status_out.stop_active};
    status_d.test_pulsed_output = {pick(status_vec, map_q[`MAP_SEL1 +: 3]),
                                   pick(status_vec, map_q[`MAP_SEL0 +: 3])};
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      status_out <= '0;
    end else begin
      status_out <= status_d;
    end
  end

endmodule // safe_stop_monitor

/* tb/safety_ctrl_model.sv */
// safety controller model: stop requests and the safe input pair
// assumes the bench sets its commands just after a core_clk edge
`timescale 1ns/1ps
module safety_ctrl_model (
  // clock
  input  wire logic                         core_clk,
  // commands from the bench
  input  wire safe_stop_pkg::stop_request_t cmd_req,
  input  wire logic [1:0]                   cmd_pair,
  // lines into the device
  output      safe_stop_pkg::stop_request_t request_in,
  output      logic [1:0]                   pair_out
);
  import safe_stop_pkg::*;
  // the controller updates its outputs once per cycle
  always @(posedge core_clk) begin
    request_in <= cmd_req;
    pair_out   <= cmd_pair;
  end
endmodule // safety_ctrl_model

/* tb/safe_stop_monitor_assertions.sv */
// checker of the safe stop monitor ports
// assumes stop deadlines are programmed no longer than DEADLINE_MS
`timescale 1ns/1ps
module safe_stop_checker #(
  parameter int TICK_CYCLES = 4,
  parameter int DEADLINE_MS = 10
) (
  // clock and reset
  input wire logic                         core_clk,
  input wire logic                         reset,
  // register port
  input wire logic [7:0]                   reg_addr,
  input wire logic [15:0]                  reg_wdata,
  input wire logic                         reg_write,
  input wire logic                         reg_read,
  input wire logic [15:0]                  reg_rdata,
  // inputs and motion
  input wire logic [1:0]                   dual_safe_input_pair,
  input wire safe_stop_pkg::stop_request_t request_in,
  input wire safe_stop_pkg::motion_t       motion_in,
  // status
  input wire safe_stop_pkg::stop_status_t  status_out
);
  import safe_stop_pkg::*;
  logic [15:0] run_q, run_d, mis_q, mis_d;
  // run length before torque off, and length of input disagreement
  always_comb begin
    run_d = (status_out.stop_active[0] && !status_out.torque_off) ? run_q + 16'h0001 : 16'h0000;
    mis_d = (dual_safe_input_pair[0] == dual_safe_input_pair[1]) ? 16'h0000 :
            (mis_q == 16'hFFFF) ? mis_q : mis_q + 16'h0001;
  end
  always_ff @(posedge core_clk) begin
    run_q <= reset ? 16'h0000 : run_d;
    mis_q <= reset ? 16'h0000 : mis_d;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_rdata_idle:
    assert property (!reg_read |=> reg_rdata == 16'h0000) else $error("read data outside read cycle");
  a_unmapped_read:
    assert property (reg_read && reg_addr == 8'hFC |=> reg_rdata == 16'h0000) else $error("unmapped read");
  a_fault_starts:
    assert property ($rose(request_in.fault_to_stop) && !status_out.stop_active[0]
      |-> ##[1:3] status_out.stop_active[0]) else $error("fault reaction did not start stop");
  a_stop_completes:
    assert property ($fell(status_out.stop_active[0])
      |-> $past(status_out.torque_off) || $past(status_out.torque_off, 2)) else $error("stop left early");
  a_deadline_bound:
    assert property (run_q <= 16'(DEADLINE_MS * TICK_CYCLES + 6)) else $error("torque off late");
  a_fail_slow:
    assert property ($rose(status_out.input_failure) |-> mis_q >= 16'(100 * TICK_CYCLES))
      else $error("input failure too early");
  a_fail_clears:
    assert property ((dual_safe_input_pair[0] == dual_safe_input_pair[1]) [*6] |=> !status_out.input_failure)
      else $error("input failure not cleared");
  a_fail_stops:
    assert property ($rose(status_out.input_failure) |-> ##[0:4] status_out.stop_active[0])
      else $error("input failure did not stop");
  c_stop: cover property ($rose(status_out.stop_active[0]));
  c_torque: cover property ($rose(status_out.torque_off));
  c_fail: cover property ($rose(status_out.input_failure));
  c_hold: cover property ($rose(status_out.hold_request[0]));
endmodule // safe_stop_checker

bind safe_stop_monitor safe_stop_checker #(.TICK_CYCLES(TICK_CYCLES)) u_safe_stop_checker (
  .core_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .dual_safe_input_pair, .request_in, .motion_in, .status_out);

/* tb/test_safe_stop_monitor.sv */
// self-checking bench of the safe stop monitor
// assumes a 4-cycle millisecond tick and the controller model in front
`timescale 1ns/1ps
`include "safe_stop_defs.svh"
module test_safe_stop_monitor;
  import safe_stop_pkg::*;
  typedef struct {logic [7:0] a; logic [15:0] v;} rd_row_t;
  typedef struct {logic [15:0] ctrl; int inst; bit src; logic [15:0] vel; logic [15:0] dec; int lo; int hi;} stop_row_t;
  logic          core_clk  = 1'b0;
  logic          reset     = 1'b1;
  logic [7:0]    reg_addr  = 8'h00;
  logic [15:0]   reg_wdata = 16'h0000;
  logic          reg_write = 1'b0;
  logic          reg_read  = 1'b0;
  logic [15:0]   reg_rdata, d;
  logic [1:0]    cmd_pair  = 2'b11;
  logic [1:0]    pair;
  stop_request_t cmd_req   = '0;
  stop_request_t request_in;
  motion_t       motion_in = '0;
  stop_status_t  status_out;
  int            n_errors  = 0;
  int            check_count = 0;
  int            n;
  // reset values: ten parameters, control, map, status, unmapped
  rd_row_t regs[14] = '{'{8'h04, 16'h0002}, '{8'h08, 16'h0001}, '{8'h0C, 16'h0001}, '{8'h10, 16'h0001},
    '{8'h14, 16'h0000}, '{8'h18, 16'h0002}, '{8'h1C, 16'h0001}, '{8'h20, 16'h0001}, '{8'h24, 16'h0000},
    '{8'h28, 16'h0000}, '{8'h00, 16'h0004}, '{8'h2C, 16'h7700}, '{8'h30, 16'h0000}, '{8'hFC, 16'h0000}};
  // control, instance, source, velocity, decel, cycle window (hi 0: no stop)
  stop_row_t stops[10] = '{'{16'h0006, 0, 1'b0, 16'h0100, 16'h0000, 36, 50},
    '{16'h0046, 0, 1'b0, 16'h0000, 16'h0010, 36, 50}, '{16'h0026, 0, 1'b0, 16'h0000, 16'h0000, 0, 14},
    '{16'h0026, 0, 1'b0, 16'h0100, 16'h0000, 36, 50}, '{16'h0066, 0, 1'b0, 16'h0100, 16'h0010, 0, 14},
    '{16'h0006, 1, 1'b0, 16'h0100, 16'h0000, 0, 0}, '{16'h000E, 1, 1'b0, 16'h0100, 16'h0000, 36, 50},
    '{16'h0004, 0, 1'b0, 16'h0100, 16'h0000, 0, 0}, '{16'h0004, 0, 1'b1, 16'h0100, 16'h0000, 36, 50},
    '{16'h0016, 2, 1'b0, 16'h0100, 16'h0000, 36, 50}};

  always #12.5 core_clk = ~core_clk;

  safety_ctrl_model u_safety_ctrl_model (.core_clk, .cmd_req, .cmd_pair, .request_in, .pair_out(pair));
  safe_stop_monitor #(.TICK_CYCLES(4)) u_safe_stop_monitor (.core_clk, .reset, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .dual_safe_input_pair(pair), .request_in, .motion_in, .status_out);

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s: %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  task automatic run_stop(input stop_row_t r);
    wr(`REG_CTRL, r.ctrl);
    motion_in <= {r.vel, r.dec};
    if (r.src) cmd_req.fault_to_stop <= 1'b1;
    else cmd_req.fieldbus_stop[r.inst] <= 1'b1;
    @(posedge core_clk);
    cmd_req <= '0;
    n = 0;
    while (status_out.torque_off !== 1'b1 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    chk(16'(status_out.torque_off), 16'(r.hi > 0), "torque off");
    if (r.hi > 0) begin
      chk(16'(n >= r.lo && n <= r.hi), 16'h0001, "stop time");
      chk(16'(status_out.stop_active[r.inst]), 16'h0001, "stop active");
    end
    repeat (6) @(negedge core_clk);
    chk(16'({status_out.stop_active, status_out.torque_off}), 16'h0000, "back to idle");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    results();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chk(16'(status_out), 16'h0000, "status after reset");
    foreach (regs[i]) begin
      rd(regs[i].a);
      chk(d, regs[i].v, "reset value");
    end
    $display("reset values done");
    wr(8'h04, 16'h000A);
    wr(8'h18, 16'h000A);
    foreach (stops[i]) run_stop(stops[i]);
    $display("controlled stops done");
    // -----------------------------------------
    // standstill: two fault reactions, hold at deadline, early hold
    // -----------------------------------------
    for (int r = 0; r < 4; r++) begin
      wr(`REG_CTRL, (r == 3) ? 16'h0004 : (r == 2) ? 16'h0206 : (16'h0286 | 16'(r << 8)));
      motion_in <= {(r == 3) ? 16'h0000 : 16'h0100, (r < 2) ? 16'h0010 : 16'h0000};
      if (r == 3) cmd_req.fault_to_standstill <= 1'b1;
      else cmd_req.fieldbus_standstill[0] <= 1'b1;
      n = 0;
      while (((r >= 2) ? status_out.hold_request[0] : status_out.standstill_fault) !== 1'b1 && n < 60) begin
        @(negedge core_clk);
        n++;
      end
      repeat (3) @(negedge core_clk);
      if (r == 2) chk(16'(status_out.hold_request[0] === 1'b1 && n >= 36), 16'h0001, "hold late");
      else if (r == 3) chk(16'(status_out.hold_request[0] === 1'b1 && n <= 14), 16'h0001, "hold early");
      else begin
        chk(16'(r ? status_out.stop_active[0] : status_out.torque_off), 16'h0001, "fault reaction");
        rd(`REG_STATUS);
        chk(16'(d[11:9]), 16'h0005, "failed code");
      end
      @(posedge core_clk);
      cmd_req <= '0;
      repeat (60) @(negedge core_clk);
      chk(16'(status_out), 16'h0000, "standstill idle");
    end
    $display("standstill done");
    wr(`REG_CTRL, 16'h0005);
    cmd_pair <= 2'b01;
    repeat (380) @(negedge core_clk);
    chk(16'(status_out.input_failure), 16'h0000, "failure early");
    repeat (60) @(negedge core_clk);
    chk(16'({status_out.input_failure, status_out.stop_active[0]}), 16'h0003, "input failure");
    @(posedge core_clk);
    cmd_pair <= 2'b11;
    repeat (60) @(negedge core_clk);
    chk(16'(status_out), 16'h0000, "failure cleared");
    $display("input failure done");
    wr(`REG_CTRL, 16'h0404);
    wr(`REG_MAP, 16'h5011);
    cmd_pair <= 2'b10;
    repeat (60) @(negedge core_clk);
    chk(16'(status_out.test_pulsed_output), 16'h0003, "pulsed outputs");
    rd(`REG_STATUS);
    chk(16'(d[7:0]), 16'h00A9, "status word");
    chk(16'(d[14:12]), 16'h0002, "hold code");
    @(posedge core_clk);
    cmd_pair <= 2'b11;
    repeat (10) @(negedge core_clk);
    chk(16'(status_out), 16'h0000, "input released");
    $display("safe input done");
    results();
  end
endmodule // test_safe_stop_monitor
